/* File: hw/scp_defines.vh */
/*
 * Constants for the serial configuration and pulse-per-second block:
 * field positions, reset values, encodings and timing counts.
 * Assumes a single system clock whose rate is given by SCP_CLK_HZ.
 */
`ifndef SCP_DEFINES_VH
`define SCP_DEFINES_VH

// ==========================================================
// Clock and timing
`define SCP_CLK_HZ 10000000
`define SCP_PPS_WIDTH_MS 100
`define SCP_PPS_HIGH_CYC ((`SCP_CLK_HZ / 1000) * `SCP_PPS_WIDTH_MS)
`define SCP_SEC_CYC (`SCP_CLK_HZ)

// ==========================================================
// Line settings byte fields
`define SCP_FRAMING_MSB 7
`define SCP_FRAMING_LSB 6
`define SCP_RATE_MSB 5
`define SCP_RATE_LSB 0
`define SCP_FRM_N81 2'h0
`define SCP_FRM_N82 2'h1
`define SCP_FRM_E81 2'h2
`define SCP_FRM_O81 2'h3
`define SCP_RATE_1200 6'h03
`define SCP_RATE_2400 6'h04
`define SCP_RATE_4800 6'h05
`define SCP_RATE_9600 6'h06
`define SCP_RATE_19200 6'h07
`define SCP_RATE_38400 6'h08
`define SCP_RATE_57600 6'h09
`define SCP_RATE_115200 6'h0A

// ==========================================================
// Report format byte fields
`define SCP_EDGE_BIT 7
`define SCP_CKSUM_BIT 6
`define SCP_POSFMT_BIT 4
`define SCP_FMT_WRITABLE 8'hD0

// ==========================================================
// Reset values and fixed codes
`define SCP_TYPE_CODE 8'h40
`define SCP_RST_ADDR 8'h01
`define SCP_RST_LINE 8'h06
`define SCP_RST_FORMAT 8'h00
`define SCP_FRAME_END 8'h0D

`endif

/* File: hw/scp_edge_counter.v */
/*
 * Edge counter whose counting edge is selectable at run time.
 * Assumes the input is already synchronous to the clock.
 */
`timescale 1ns/1ps

module scp_edge_counter #(
   parameter WIDTH = 16
) (
   sys_clk,
   rst_sync_n,
   sig_in,
   rise_sel,
   count_q
);
   input sys_clk;
   input rst_sync_n;
   input sig_in;
   input rise_sel;
   output [WIDTH-1:0] count_q;

   wire sys_clk;
   wire rst_sync_n;
   wire sig_in;
   wire rise_sel;
   reg [WIDTH-1:0] count_q;
   reg sig_prev_q;
   wire rise_w;
   wire fall_w;

   // ==========================================================
   // Edge detection on the previous sample
   assign rise_w = sig_in & ~sig_prev_q;
   assign fall_w = ~sig_in & sig_prev_q;

   // Counter advances on the selected edge only
   always @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sig_prev_q <= 1'b0;
         count_q <= {WIDTH{1'b0}};
      end else begin
         sig_prev_q <= sig_in;
         if (rise_sel ? rise_w : fall_w) begin // see (R6)
            count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule

/* File: hw/scp_top.v */
/*
 * Configuration store, frame checksum helper and pulse-per-second
 * generator for a serial-networked receiver module.
 * Assumes a command decoder upstream that delivers received frame
 * characters and configuration writes, synchronous to sys_clk.
 */
// Functional notes
// (R1) With valid reception, a 100 ms pulse starts every second.
// (R2) Line settings bits 7:6 pick parity and stop-bit framing.
// (R3) Line settings bits 5:0 codes 03..0A pick 1200..115200 baud.
// (R4) Type code always reads 40; writes to it are ignored.
// (R5) Format byte: bit7 edge, bit6 checksum, bit4 report format, rest zero.
// (R6) Edge select 0 counts falling edges, 1 counts rising edges.
// (R7) Report format select 0 gives NMEA style, 1 map decimal style.
// (R8) After reset: Modbus RTU, address 01, 9600 baud.
// (R9) Checksum is the low byte of the sum of frame characters.
// (R10) A carriage return 0x0D ends every frame.
// (R11) Without valid reception the pulse output stays low.
`timescale 1ns/1ps
`include "scp_defines.vh"

module scp_top #(
   parameter SEC_CYC = `SCP_SEC_CYC,
   parameter PPS_HIGH_CYC = `SCP_PPS_HIGH_CYC,
   parameter CNT_WIDTH = 16
) (
   sys_clk,
   rst_n,
   cfg_wr_stb,
   cfg_addr_in,
   cfg_type_in,
   cfg_line_in,
   cfg_format_in,
   char_valid,
   char_data,
   counter_in,
   sat_fix_valid,
   module_addr_q,
   line_settings_byte_q,
   report_format_byte_q,
   fixed_type_code_q,
   parity_en_q,
   parity_odd_q,
   two_stop_q,
   baud_div_q,
   cksum_en_q,
   position_format_select_q,
   proto_modbus_q,
   edge_count_q,
   frame_end_q,
   frame_sum_q,
   cksum_ok_q,
   pps_q
);
   input sys_clk;
   input rst_n;
   input cfg_wr_stb;
   input [7:0] cfg_addr_in;
   input [7:0] cfg_type_in;
   input [7:0] cfg_line_in;
   input [7:0] cfg_format_in;
   input char_valid;
   input [7:0] char_data;
   input counter_in;
   input sat_fix_valid;
   output reg [7:0] module_addr_q;
   output reg [7:0] line_settings_byte_q;
   output reg [7:0] report_format_byte_q;
   output reg [7:0] fixed_type_code_q;
   output reg parity_en_q;
   output reg parity_odd_q;
   output reg two_stop_q;
   output reg [15:0] baud_div_q;
   output reg cksum_en_q;
   output reg position_format_select_q;
   output reg proto_modbus_q;
   output [CNT_WIDTH-1:0] edge_count_q;
   output reg frame_end_q;
   output reg [7:0] frame_sum_q;
   output reg cksum_ok_q;
   output reg pps_q;

   reg rst_meta_q;
   reg rst_sync_q;
   wire rst_sync_n;
   reg [7:0] sum_q;
   reg [7:0] sum_m1_q;
   reg [7:0] sum_m2_q;
   reg [7:0] last1_q;
   reg [7:0] last2_q;
   reg [31:0] sec_cnt_q;
   reg fix_prev_q;
   wire rate_ok_w;
   wire [7:0] line_d;
   wire [7:0] rx_cksum_w;
   wire rx_hex_ok_w;
   wire [4:0] hex_hi_w;
   wire [4:0] hex_lo_w;

   // Constants held at 32 bits so that narrowing them is a visible slice
   localparam [31:0] RST_DIV = `SCP_CLK_HZ / 9600;
   localparam [31:0] SEC_LAST = SEC_CYC - 1;
   localparam [31:0] PPS_LAST = PPS_HIGH_CYC - 1;

   // ==========================================================
   // Reset synchroniser: asserts at once, releases after two edges
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_sync_n = rst_sync_q;

   // ==========================================================
   // Rate code to bit period in system clocks
   function [15:0] rate_div;
      input [5:0] code;
      reg [31:0] div;
      begin
         case (code)
            `SCP_RATE_1200: div = `SCP_CLK_HZ / 1200;
            `SCP_RATE_2400: div = `SCP_CLK_HZ / 2400;
            `SCP_RATE_4800: div = `SCP_CLK_HZ / 4800;
            `SCP_RATE_9600: div = `SCP_CLK_HZ / 9600;
            `SCP_RATE_19200: div = `SCP_CLK_HZ / 19200;
            `SCP_RATE_38400: div = `SCP_CLK_HZ / 38400;
            `SCP_RATE_57600: div = `SCP_CLK_HZ / 57600;
            `SCP_RATE_115200: div = `SCP_CLK_HZ / 115200;
            default: div = 32'h00000000;
         endcase
         rate_div = div[15:0];
      end
   endfunction

   // One upper-case hex digit to its value; bit 4 flags a bad digit
   function [4:0] hex_val;
      input [7:0] ch;
      begin
         if (ch >= 8'h30 && ch <= 8'h39) begin
            hex_val = {1'b0, ch[3:0]};
         end else if (ch >= 8'h41 && ch <= 8'h46) begin
            hex_val = {1'b0, ch[3:0] + 4'h9};
         end else begin
            hex_val = 5'h10;
         end
      end
   endfunction

   // An unsupported rate code is dropped so the link never loses its rate
   assign rate_ok_w = (rate_div(cfg_line_in[`SCP_RATE_MSB:`SCP_RATE_LSB]) != 16'h0000);
   assign line_d = rate_ok_w ? cfg_line_in : line_settings_byte_q;

   // ==========================================================
   // Configuration store and decoded settings
   always @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         module_addr_q <= `SCP_RST_ADDR; // see (R8)
         line_settings_byte_q <= `SCP_RST_LINE; // see (R8)
         report_format_byte_q <= `SCP_RST_FORMAT;
         fixed_type_code_q <= `SCP_TYPE_CODE;
         parity_en_q <= 1'b0;
         parity_odd_q <= 1'b0;
         two_stop_q <= 1'b0;
         baud_div_q <= RST_DIV[15:0]; // see (R8)
         cksum_en_q <= 1'b0;
         position_format_select_q <= 1'b0;
         proto_modbus_q <= 1'b1; // see (R8)
      end else begin
         // Type code input is accepted on the bus but never stored
         fixed_type_code_q <= `SCP_TYPE_CODE; // see (R4)
         if (cfg_wr_stb) begin
            module_addr_q <= cfg_addr_in;
            line_settings_byte_q <= line_d;
            // Reserved bits are forced to zero in case the host slips
            report_format_byte_q <= cfg_format_in & `SCP_FMT_WRITABLE; // see (R5)
            case (line_d[`SCP_FRAMING_MSB:`SCP_FRAMING_LSB]) // see (R2)
               `SCP_FRM_N81: begin
                  parity_en_q <= 1'b0;
                  parity_odd_q <= 1'b0;
                  two_stop_q <= 1'b0;
               end
               `SCP_FRM_N82: begin
                  parity_en_q <= 1'b0;
                  parity_odd_q <= 1'b0;
                  two_stop_q <= 1'b1;
               end
               `SCP_FRM_E81: begin
                  parity_en_q <= 1'b1;
                  parity_odd_q <= 1'b0;
                  two_stop_q <= 1'b0;
               end
               default: begin
                  parity_en_q <= 1'b1;
                  parity_odd_q <= 1'b1;
                  two_stop_q <= 1'b0;
               end
            endcase
            baud_div_q <= rate_div(line_d[`SCP_RATE_MSB:`SCP_RATE_LSB]); // see (R3)
            cksum_en_q <= cfg_format_in[`SCP_CKSUM_BIT]; // see (R5)
            position_format_select_q <= cfg_format_in[`SCP_POSFMT_BIT]; // see (R7)
         end
      end
   end

   // ==========================================================
   // Input edge counter steered by the edge select bit
   scp_edge_counter #(
      .WIDTH(CNT_WIDTH)
   ) u_counter (
      .sys_clk(sys_clk),
      .rst_sync_n(rst_sync_n),
      .sig_in(counter_in),
      .rise_sel(report_format_byte_q[`SCP_EDGE_BIT]), // see (R6)
      .count_q(edge_count_q)
   );

   // ==========================================================
   // Frame checksum: lagged sums let the two checksum characters
   // be left out of the sum without knowing the frame length
   assign hex_hi_w = hex_val(last2_q);
   assign hex_lo_w = hex_val(last1_q);
   assign rx_cksum_w = {hex_hi_w[3:0], hex_lo_w[3:0]};
   assign rx_hex_ok_w = ~hex_hi_w[4] & ~hex_lo_w[4];

   always @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sum_q <= 8'h00;
         sum_m1_q <= 8'h00;
         sum_m2_q <= 8'h00;
         last1_q <= 8'h00;
         last2_q <= 8'h00;
         frame_end_q <= 1'b0;
         frame_sum_q <= 8'h00;
         cksum_ok_q <= 1'b0;
      end else begin
         frame_end_q <= 1'b0;
         if (char_valid && char_data == `SCP_FRAME_END) begin // see (R10)
            frame_end_q <= 1'b1;
            if (cksum_en_q) begin
               frame_sum_q <= sum_m2_q; // see (R9)
               cksum_ok_q <= rx_hex_ok_w && (rx_cksum_w == sum_m2_q); // see (R9)
            end else begin
               frame_sum_q <= sum_q; // see (R9)
               cksum_ok_q <= 1'b1;
            end
            sum_q <= 8'h00;
            sum_m1_q <= 8'h00;
            sum_m2_q <= 8'h00;
            last1_q <= 8'h00;
            last2_q <= 8'h00;
         end else if (char_valid) begin
            // Carry beyond eight bits is dropped, which is the masking
            sum_q <= sum_q + char_data; // see (R9)
            sum_m1_q <= sum_q;
            sum_m2_q <= sum_m1_q;
            last1_q <= char_data;
            last2_q <= last1_q;
         end
      end
   end

   // ==========================================================
   // Pulse per second: the second restarts when reception returns,
   // so the first pulse lines up with the receiver's second mark
   always @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sec_cnt_q <= 32'h00000000;
         fix_prev_q <= 1'b0;
         pps_q <= 1'b0;
      end else begin
         fix_prev_q <= sat_fix_valid;
         if (!sat_fix_valid) begin
            sec_cnt_q <= 32'h00000000;
            pps_q <= 1'b0; // see (R11)
         end else if (!fix_prev_q || sec_cnt_q == SEC_LAST) begin
            sec_cnt_q <= 32'h00000000;
            pps_q <= 1'b1; // see (R1)
         end else begin
            sec_cnt_q <= sec_cnt_q + 32'h00000001;
            pps_q <= (sec_cnt_q < PPS_LAST); // see (R1)
         end
      end
   end
endmodule

/* File: testbench/scp_chk_sva.sv */
/* Port checker for scp_top: config decode, frame end and pulse output.
   Assumes the bench shrinks the pulse counts through parameters. */
`timescale 1ns/1ps
module scp_chk #(
   parameter PPS_HIGH_CYC = 5
) (
   input logic sys_clk,
   input logic rst_n,
   input logic cfg_wr_stb,
   input logic [7:0] cfg_line_in,
   input logic [7:0] cfg_format_in,
   input logic char_valid,
   input logic [7:0] char_data,
   input logic counter_in,
   input logic sat_fix_valid,
   input logic [7:0] line_settings_byte_q,
   input logic [7:0] report_format_byte_q,
   input logic [7:0] fixed_type_code_q,
   input logic parity_en_q,
   input logic parity_odd_q,
   input logic two_stop_q,
   input logic cksum_en_q,
   input logic position_format_select_q,
   input logic [15:0] edge_count_q,
   input logic frame_end_q,
   input logic pps_q
);
   // ==========================================================
   // Helpers
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic [23:0] hi_q;
   logic rate_ok;
   assign rate_ok = cfg_line_in[5:0] >= 6'h03 && cfg_line_in[5:0] <= 6'h0A;
   // Pulse length so far, judged where the pulse falls
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) hi_q <= 24'h000000;
      else hi_q <= pps_q ? hi_q + 24'h000001 : 24'h000000;
   end
   sequence s_fix_up; $rose(sat_fix_valid); endsequence
   sequence s_cr; char_valid && char_data == 8'h0D; endsequence
   sequence s_end; frame_end_q ##1 !frame_end_q; endsequence
   // ==========================================================
   // Properties
   property p_pps_start; s_fix_up |=> pps_q; endproperty
   property p_pps_len; $fell(pps_q) && sat_fix_valid |-> hi_q == PPS_HIGH_CYC; endproperty
   property p_pps_off; !sat_fix_valid |=> !pps_q; endproperty
   property p_type; fixed_type_code_q == 8'h40; endproperty
   property p_fmt; cfg_wr_stb |=> report_format_byte_q == ($past(cfg_format_in) & 8'hD0);
   endproperty
   property p_line_ok; cfg_wr_stb && rate_ok |=> line_settings_byte_q == $past(cfg_line_in);
   endproperty
   property p_line_bad; cfg_wr_stb && !rate_ok |=> $stable(line_settings_byte_q); endproperty
   property p_framing; parity_en_q == line_settings_byte_q[7] && two_stop_q ==
      (line_settings_byte_q[7:6] == 2'h1) && parity_odd_q == (&line_settings_byte_q[7:6]);
   endproperty
   property p_sel; cksum_en_q == report_format_byte_q[6] &&
      position_format_select_q == report_format_byte_q[4]; endproperty
   property p_edge; ($rose(counter_in) && report_format_byte_q[7]) || ($fell(counter_in) &&
      !report_format_byte_q[7]) |-> ##[1:2] $changed(edge_count_q); endproperty
   property p_end; s_cr |-> ##[1:2] s_end; endproperty
   a_pps_start: assert property (p_pps_start) else $error("pulse missing");
   a_pps_len: assert property (p_pps_len) else $error("pulse length");
   a_pps_off: assert property (p_pps_off) else $error("pulse without fix");
   a_type: assert property (p_type) else $error("type code");
   a_fmt: assert property (p_fmt) else $error("format byte");
   a_line_ok: assert property (p_line_ok) else $error("line byte");
   a_line_bad: assert property (p_line_bad) else $error("bad rate taken");
   a_framing: assert property (p_framing) else $error("framing decode");
   a_sel: assert property (p_sel) else $error("format decode");
   a_edge: assert property (p_edge) else $error("edge not counted");
   a_end: assert property (p_end) else $error("frame end");
endmodule
bind scp_top scp_chk #(.PPS_HIGH_CYC(PPS_HIGH_CYC)) u_scp_chk (.sys_clk(sys_clk),
   .rst_n(rst_n), .cfg_wr_stb(cfg_wr_stb), .cfg_line_in(cfg_line_in),
   .cfg_format_in(cfg_format_in), .char_valid(char_valid), .char_data(char_data),
   .counter_in(counter_in), .sat_fix_valid(sat_fix_valid),
   .line_settings_byte_q(line_settings_byte_q), .report_format_byte_q(report_format_byte_q),
   .fixed_type_code_q(fixed_type_code_q), .parity_en_q(parity_en_q),
   .parity_odd_q(parity_odd_q), .two_stop_q(two_stop_q), .cksum_en_q(cksum_en_q),
   .position_format_select_q(position_format_select_q), .edge_count_q(edge_count_q),
   .frame_end_q(frame_end_q), .pps_q(pps_q));

/* File: testbench/scp_host.sv */
/* Host model: config writes and framed characters.
   Assumes the bench calls its tasks; all changes land on falling edges. */
`timescale 1ns/1ps
module scp_host (
   input wire logic sys_clk,
   output logic cfg_wr_stb,
   output logic [7:0] cfg_addr_in,
   output logic [7:0] cfg_type_in,
   output logic [7:0] cfg_line_in,
   output logic [7:0] cfg_format_in,
   output logic char_valid,
   output logic [7:0] char_data
);
   // ==========================================================
   // Idle state; released data lines show the inverse of the last value
   initial begin
      {cfg_wr_stb, char_valid} = 2'h0;
      {cfg_addr_in, cfg_type_in, cfg_line_in, cfg_format_in, char_data} = 40'h0;
   end
   function automatic logic [7:0] hex(input logic [3:0] d);
      return (d < 4'hA) ? 8'h30 + d : 8'h37 + d;
   endfunction
   // Bytes go out as given, so a scenario may set reserved bits
   task automatic write_cfg(input logic [7:0] a, t, l, f);
      @(negedge sys_clk);
      cfg_wr_stb = 1'b1;
      {cfg_addr_in, cfg_type_in, cfg_line_in, cfg_format_in} = {a, t, l, f};
      @(negedge sys_clk);
      cfg_wr_stb = 1'b0;
      {cfg_addr_in, cfg_type_in, cfg_line_in, cfg_format_in} = ~{a, t, l, f};
   endtask
   task automatic send_char(input logic [7:0] c);
      @(negedge sys_clk);
      char_valid = 1'b1;
      char_data = c;
      @(negedge sys_clk);
      char_valid = 1'b0;
      char_data = ~c;
   endtask
   // A wrong checksum is sent only when the scenario asks for one
   task automatic send_frame(input string s, input logic ck, input logic bad);
      logic [7:0] sum;
      sum = {7'h00, bad};
      for (int i = 0; i < s.len(); i++) begin
         sum += s[i];
         send_char(s[i]);
      end
      if (ck) begin
         send_char(hex(sum[7:4]));
         send_char(hex(sum[3:0]));
      end
      send_char(8'h0D);
   endtask
endmodule

/* File: testbench/tb.sv */
/* Self-checking bench for scp_top with the host model.
   Assumes shortened pulse counts: 50-cycle second, 5-cycle pulse. */
`timescale 1ns/1ps
module tb;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic counter_in = 1'b0;
   logic sat_fix_valid = 1'b0;
   logic wr, cv, par, odd, two, ck_en, pos, modbus, fend, ok, pps;
   logic [7:0] addr, typ, line, fmt, cd, m_addr, line_q, fmt_q, type_q, sum_q;
   logic [15:0] baud, cnt;
   int failures = 0;
   int n_compared = 0;
   int n_end = 0;
   always #50 sys_clk = ~sys_clk;
   scp_host u_scp_host (.sys_clk(sys_clk), .cfg_wr_stb(wr), .cfg_addr_in(addr),
      .cfg_type_in(typ), .cfg_line_in(line), .cfg_format_in(fmt), .char_valid(cv),
      .char_data(cd));
   scp_top #(.SEC_CYC(50), .PPS_HIGH_CYC(5)) u_scp_top (.sys_clk(sys_clk), .rst_n(rst_n),
      .cfg_wr_stb(wr), .cfg_addr_in(addr), .cfg_type_in(typ), .cfg_line_in(line),
      .cfg_format_in(fmt), .char_valid(cv), .char_data(cd), .counter_in(counter_in),
      .sat_fix_valid(sat_fix_valid), .module_addr_q(m_addr), .line_settings_byte_q(line_q),
      .report_format_byte_q(fmt_q), .fixed_type_code_q(type_q), .parity_en_q(par),
      .parity_odd_q(odd), .two_stop_q(two), .baud_div_q(baud), .cksum_en_q(ck_en),
      .position_format_select_q(pos), .proto_modbus_q(modbus), .edge_count_q(cnt),
      .frame_end_q(fend), .frame_sum_q(sum_q), .cksum_ok_q(ok), .pps_q(pps));
   // Frame-end pulses, counted where they are settled
   always @(negedge sys_clk) if (fend === 1'b1) n_end++;
   // ==========================================================
   // Shared tasks
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset;
      check("addr", m_addr, 8'h01);
      check("line", line_q, 8'h06);
      check("baud", baud, 16'h0411);
      check("modbus", modbus, 1'b1);
      check("pps", pps, 1'b0);
      $display("test reset done");
   endtask
   task automatic t_line;
      logic [7:0] v;
      logic [15:0] div [8];
      div = '{16'h208D, 16'h1046, 16'h0823, 16'h0411, 16'h0208, 16'h0104, 16'h00AD, 16'h0056};
      for (int i = 0; i < 8; i++) begin
         v = {i[1:0], 6'h03 + i[5:0]};
         u_scp_host.write_cfg(8'h23, 8'h55, v, 8'h00);
         check("line", line_q, v);
         check("baud", baud, div[i]);
         check("framing", {par, odd, two}, {v[7], &v[7:6], v[7:6] == 2'h1});
         check("type", type_q, 8'h40);
      end
      u_scp_host.write_cfg(8'h01, 8'h00, 8'h0B, 8'h00);
      check("refused", line_q, v);
      $display("test line done");
   endtask
   task automatic t_fmt;
      u_scp_host.write_cfg(8'h01, 8'h00, 8'h06, 8'hFF);
      check("fmt", fmt_q, 8'hD0);
      check("sel", {ck_en, pos}, 2'h3);
      u_scp_host.write_cfg(8'h01, 8'h00, 8'h06, 8'h40);
      check("sel", {ck_en, pos}, 2'h2);
      $display("test format done");
   endtask
   // Three pulses give three edges of each kind; only one kind counts
   task automatic t_cnt(input logic rise);
      logic [15:0] c0;
      u_scp_host.write_cfg(8'h01, 8'h00, 8'h06, {rise, 7'h40});
      c0 = cnt;
      repeat (3) begin
         counter_in = 1'b1;
         cycles(3);
         counter_in = 1'b0;
         cycles(3);
      end
      check("count", cnt, c0 + 16'h0003);
      $display("test counter done");
   endtask
   task automatic t_frame(input logic ck, input logic bad);
      int e0;
      u_scp_host.write_cfg(8'h01, 8'h00, 8'h06, {1'b0, ck, 6'h00});
      e0 = n_end;
      u_scp_host.send_frame("$012", ck, bad);
      cycles(3);
      check("ends", n_end - e0, 16'h0001);
      check("sum", sum_q, 8'hB7);
      check("ok", ok, !bad);
      $display("test frame done");
   endtask
   task automatic t_pps;
      logic [15:0] hi, rises;
      logic last;
      {hi, rises, last} = '0;
      sat_fix_valid = 1'b1;
      repeat (100) begin
         cycles(1);
         hi += pps;
         rises += (pps && !last);
         last = pps;
      end
      check("pps_high", hi, 16'h000A);
      check("pps_rises", rises, 16'h0002);
      sat_fix_valid = 1'b0;
      hi = 0;
      repeat (20) begin
         cycles(1);
         hi += pps;
      end
      check("pps_off", hi, 16'h0000);
      $display("test pulse done");
   endtask
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      cycles(8);
      rst_n = 1'b1;
      cycles(4);
      t_reset;
      t_line;
      t_fmt;
      t_cnt(1'b0);
      t_cnt(1'b1);
      t_frame(1'b1, 1'b0);
      t_frame(1'b1, 1'b1);
      t_frame(1'b0, 1'b0);
      t_pps;
      report_and_stop;
   end
   // About 250 cycles are needed; sixteen times that means a hang
   initial begin
      cycles(4000);
      failures++;
      $display("watchdog expired");
      report_and_stop;
   end
endmodule
